// ===== common/sysconfig_prio_pkg.sv
// package: register map, field layout and reset values for priority and pin-select registers
package sysconfig_prio_pkg;

  // register byte offsets
  localparam logic [3:0] off_fault_status    = 4'h0;
  localparam logic [3:0] off_master_prio_0   = 4'h4;
  localparam logic [3:0] off_master_prio_1   = 4'h8;
  localparam logic [3:0] off_master_prio_2   = 4'hc;
  localparam logic [5:0] off_pin_select_0    = 6'h10;
  localparam int         addr_width          = 4;

  // priority field layout
  localparam int prio_w = 3;
  localparam int n_prio_fields = 8;

  // reset values of the three priority registers
  localparam logic [31:0] master_prio_0_rst = 32'h4444_2222;
  localparam logic [31:0] master_prio_1_rst = 32'h4444_0000;
  localparam logic [31:0] master_prio_2_rst = 32'h5460_4404;

  // read-only zero bits of priority registers 0 and 1
  localparam logic [31:0] prio_ro_zero_mask = 32'h0000_0888;

  // pin select layout
  localparam int          sel_w           = 4;
  localparam int          top_field_lsb   = 28;
  localparam logic [31:0] pin_select_rst  = 32'h0000_0000;

  // pin-select top field codes
  localparam logic [3:0] sel_deep_sleep    = 4'h0;
  localparam logic [3:0] sel_rtc_alarm     = 4'h2;
  localparam logic [3:0] sel_serial2_cts   = 4'h4;
  localparam logic [3:0] sel_gpio_bank0_b8 = 4'h8;

  // bus response codes
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_decerr = 2'b11;

  // fault type codes
  localparam int         fault_type_w     = 6;
  localparam logic [5:0] fault_none       = 6'h00;
  localparam logic [5:0] fault_user_exec  = 6'h01;
  localparam logic [5:0] fault_user_write = 6'h02;
  localparam logic [5:0] fault_user_read  = 6'h04;
  localparam logic [5:0] fault_sup_exec   = 6'h08;
  localparam logic [5:0] fault_sup_write  = 6'h10;
  localparam logic [5:0] fault_sup_read   = 6'h20;

endpackage

// ===== rtl/fault_capture.sv
// first-fault type capture for the fault status register
`timescale 1ns/1ns
module fault_capture
  import sysconfig_prio_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // fault report
  input  wire logic       fault_valid,
  input  wire logic       fault_user,
  input  wire logic       fault_exec,
  input  wire logic       fault_write,
  input  wire logic       fault_clear,
  // captured type
  output logic [5:0]      fault_type
);

  logic [5:0] next_fault_type;

  always_comb
  begin
    if (fault_exec)
      next_fault_type = fault_user ? fault_user_exec : fault_sup_exec;
    else if (fault_write)
      next_fault_type = fault_user ? fault_user_write : fault_sup_write;
    else
      next_fault_type = fault_user ? fault_user_read : fault_sup_read;
  end

  // only the first fault is kept; a new fault beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_type <= fault_none;
    else if (fault_valid && (fault_type == fault_none || fault_clear))
      fault_type <= next_fault_type;
    else if (fault_clear)
      fault_type <= fault_none;
  end

endmodule

// ===== rtl/pin_top_mux.sv
// output steering for the pin owned by the top pin-select field
`timescale 1ns/1ns
module pin_top_mux
  import sysconfig_prio_pkg::*;
(
  // select
  input  wire logic [3:0] sel,
  // peripheral outputs
  input  wire logic       rtc_alarm_out,
  input  wire logic       gpio_out,
  input  wire logic       gpio_oe_n,
  // pin buffer
  output logic            pin_out,
  output logic            pin_oe_n
);

  // input-only functions leave the buffer undriven; reserved codes likewise
  always_comb
  begin
    case (sel)
      sel_rtc_alarm:
      begin
        pin_out  = rtc_alarm_out;
        pin_oe_n = 1'b0;
      end
      sel_gpio_bank0_b8:
      begin
        pin_out  = gpio_out;
        pin_oe_n = gpio_oe_n;
      end
      default:
      begin
        pin_out  = 1'b0;
        pin_oe_n = 1'b1;
      end
    endcase
  end

endmodule

// ===== rtl/sysconfig_priority_pinmux_regs.sv
// register bank: fault type, master priorities and pin select, Avalon-MM slave
// What this block does
// - first fault type kept in bits 5-0
// - fault type one-hot user/supervisor exec/write/read
// - priority fields 3 bits, 0 highest
// - reg0 instruction/data priorities, reset 2
// - reg0 streaming port priority bits 18-16
// - reg1 three dma priorities at 18/14/10
// - reg1 realtime unit priorities, reset 0
// - reg1 video dma priorities, reset 4
// - reg2 display priority bits 30-28, reset 5
// - reg2 host port priority, reset 6
// - reg2 usb priorities, reset 4
// - bits 11,7,3 of reg0/1 read zero
// - four-bit select field per pin
// - select only steers output and enable
// - pin input reaches all sharers always
// - no hardware check of pin configuration
// - top field codes 0,2,4,8; others reserved
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module sysconfig_priority_pinmux_regs
  import sysconfig_prio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  // fault report from the protection logic
  input  wire logic        fault_valid,
  input  wire logic        fault_user,
  input  wire logic        fault_exec,
  input  wire logic        fault_write,
  input  wire logic        fault_clear,
  // arbiter priorities
  output logic [2:0]       cpu_instr_prio,
  output logic [2:0]       cpu_data_prio,
  output logic [2:0]       parallel_stream_port_prio,
  output logic [2:0]       video_dma_b_prio,
  output logic [2:0]       video_dma_a_prio,
  output logic [2:0]       dma_ctl1_tc_a_prio,
  output logic [2:0]       dma_ctl0_tc_b_prio,
  output logic [2:0]       dma_ctl0_tc_a_prio,
  output logic [2:0]       rt_unit_b_prio,
  output logic [2:0]       rt_unit_a_prio,
  output logic [2:0]       display_ctl_prio,
  output logic [2:0]       host_port_prio,
  output logic [2:0]       usb_dma_port_prio,
  output logic [2:0]       usb_cfg_port_prio,
  // pin select fields
  output logic [31:0]      pin_select_0,
  // shared pin: peripheral side
  input  wire logic        rtc_alarm_out,
  input  wire logic        gpio_bank0_bit8_out,
  input  wire logic        gpio_bank0_bit8_oe_n,
  output logic             deep_sleep_input,
  output logic             serial2_clear_to_send,
  output logic             gpio_bank0_bit8_in,
  // shared pin: buffer side
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n
);

  logic [31:0] master_priority_0;
  logic [31:0] master_priority_1;
  logic [31:0] master_priority_2;
  logic [5:0]  fault_type;
  logic        ack;
  logic [2:0]  pin_sync;
  logic        pin_level;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    return a == off;
  endfunction

  // one wait state: the answer comes on the edge after the request is seen
  always_ff @(posedge clk)
  begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (read || write) && !ack;
  end

  assign waitrequest = (read || write) && !ack;

  wire wr_take = write && ack;

  // priority registers; bits 11,7,3 of reg0/1 forced to zero, other reserved fields are plain storage, software keeps defaults
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      master_priority_0 <= master_prio_0_rst;
      master_priority_1 <= master_prio_1_rst;
      master_priority_2 <= master_prio_2_rst;
    end
    else if (wr_take)
    begin
      if (hit(address, {2'b00, off_master_prio_0}))
        master_priority_0 <= merge(master_priority_0, writedata, byteenable) & ~prio_ro_zero_mask;
      if (hit(address, {2'b00, off_master_prio_1}))
        master_priority_1 <= merge(master_priority_1, writedata, byteenable) & ~prio_ro_zero_mask;
      if (hit(address, {2'b00, off_master_prio_2}))
        master_priority_2 <= merge(master_priority_2, writedata, byteenable);
    end
  end

  // pin select register, one nibble per pin
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_select_0 <= pin_select_rst;
    else if (wr_take && hit(address, off_pin_select_0))
      pin_select_0 <= merge(pin_select_0, writedata, byteenable);
  end

  // read path
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      readdata <= 32'h0000_0000;
      response <= resp_okay;
    end
    else if ((read || write) && !ack)
    begin
      response <= resp_okay;
      readdata <= 32'h0000_0000;
      case (address)
        {2'b00, off_fault_status}:  readdata <= {26'h0, fault_type};
        {2'b00, off_master_prio_0}: readdata <= master_priority_0;
        {2'b00, off_master_prio_1}: readdata <= master_priority_1;
        {2'b00, off_master_prio_2}: readdata <= master_priority_2;
        off_pin_select_0:           readdata <= pin_select_0;
        default:                    response <= resp_decerr;
      endcase
    end
  end

  fault_capture u_fault
  (
    .clk         (clk),
    .rst         (rst),
    .fault_valid (fault_valid),
    .fault_user  (fault_user),
    .fault_exec  (fault_exec),
    .fault_write (fault_write),
    .fault_clear (fault_clear),
    .fault_type  (fault_type)
  );

  // priorities driven straight from storage, no extra latency
  assign cpu_instr_prio            = master_priority_0[2:0];
  assign cpu_data_prio             = master_priority_0[6:4];
  assign parallel_stream_port_prio = master_priority_0[18:16];
  assign rt_unit_a_prio            = master_priority_1[2:0];
  assign rt_unit_b_prio            = master_priority_1[6:4];
  assign dma_ctl0_tc_a_prio        = master_priority_1[10:8];
  assign dma_ctl0_tc_b_prio        = master_priority_1[14:12];
  assign dma_ctl1_tc_a_prio        = master_priority_1[18:16];
  assign video_dma_a_prio          = master_priority_1[26:24];
  assign video_dma_b_prio          = master_priority_1[30:28];
  assign usb_cfg_port_prio         = master_priority_2[10:8];
  assign usb_dma_port_prio         = master_priority_2[14:12];
  assign host_port_prio            = master_priority_2[22:20];
  assign display_ctl_prio          = master_priority_2[30:28];

  // pin input synchroniser; a change counts when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_sync <= 3'h0;
    else
      pin_sync <= {pin_sync[1:0], pin_in};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pin_level <= 1'b0;
    else if (pin_sync[1] == pin_sync[2])
      pin_level <= pin_sync[2];
  end

  // input fans out regardless of select; sharers must ignore it when not owner
  assign deep_sleep_input      = pin_level;
  assign serial2_clear_to_send = pin_level;
  assign gpio_bank0_bit8_in    = pin_level;

  // no consistency check against peripheral mode: software owns that
  pin_top_mux u_top_mux
  (
    .sel           (pin_select_0[top_field_lsb +: sel_w]),
    .rtc_alarm_out (rtc_alarm_out),
    .gpio_out      (gpio_bank0_bit8_out),
    .gpio_oe_n     (gpio_bank0_bit8_oe_n),
    .pin_out       (pin_out),
    .pin_oe_n      (pin_oe_n)
  );

endmodule

// ===== test/pin_buffer_model.sv
// pin buffer model: resolves the shared pin level seen by the block
`timescale 1ns/1ns
module pin_buffer_model
(
  // device side
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // board side
  input  wire logic ext_drive,
  input  wire logic ext_level,
  // level back to the block
  output logic      pin_in
);
  // pull-up when nobody drives; device wins a clash so steering stays visible
  assign pin_in = !pin_oe_n ? pin_out : (ext_drive ? ext_level : 1'b1);
endmodule

// ===== test/prio_regs_properties.sv
// checker: bus answer, priority outputs and pin steering properties
`timescale 1ns/1ns
module prio_regs_props
(
  // clock and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  // priorities
  input wire logic [2:0]  cpu_instr_prio,
  input wire logic [2:0]  display_ctl_prio,
  // pin
  input wire logic [31:0] pin_select_0,
  input wire logic        rtc_alarm_out,
  input wire logic        gpio_bank0_bit8_out,
  input wire logic        gpio_bank0_bit8_oe_n,
  input wire logic        pin_in,
  input wire logic        deep_sleep_input,
  input wire logic        serial2_clear_to_send,
  input wire logic        gpio_bank0_bit8_in,
  input wire logic        pin_out,
  input wire logic        pin_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [3:0] top_sel = pin_select_0[31:28];
  wire       rd_done = read && !waitrequest;
  wire       wr_done = write && !waitrequest;

  chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_ro_zero: assert property (rd_done && address inside {6'h04, 6'h08} |-> !(|(readdata & 32'h0000_0888)))
    else $error("reserved priority bit reads one");
  chk_bad_addr: assert property (rd_done && address > 6'h10 |-> response == 2'b11 && readdata == 32'h0)
    else $error("unmapped read not refused");
  chk_instr_update: assert property (wr_done && address == 6'h04 && byteenable[0] |=> cpu_instr_prio == $past(writedata[2:0]))
    else $error("instruction priority not updated");
  chk_display_update: assert property (wr_done && address == 6'h0c && byteenable[3] |=> display_ctl_prio == $past(writedata[30:28]))
    else $error("display priority not updated");
  chk_select_store: assert property (wr_done && address == 6'h10 && byteenable == 4'hf |=> pin_select_0 == $past(writedata))
    else $error("pin select not stored");
  chk_rtc_drive: assert property (top_sel == 4'h2 |-> !pin_oe_n && pin_out == rtc_alarm_out)
    else $error("alarm not steered to pin");
  chk_gpio_drive: assert property (top_sel == 4'h8 |-> pin_out == gpio_bank0_bit8_out && pin_oe_n == gpio_bank0_bit8_oe_n)
    else $error("gpio not steered to pin");
  chk_pin_release: assert property (top_sel != 4'h2 && top_sel != 4'h8 |-> pin_oe_n)
    else $error("pin driven by an input-only code");
  chk_input_fanout: assert property ($stable(pin_in)[*6] |-> {deep_sleep_input, serial2_clear_to_send, gpio_bank0_bit8_in} == {3{pin_in}})
    else $error("pin level not fanned out");

  cov_bad_read: cover property (rd_done && address > 6'h10);
  cov_gpio_sel: cover property (top_sel == 4'h8);
  cov_prio2_wr: cover property (wr_done && address == 6'h0c);
endmodule

bind sysconfig_priority_pinmux_regs prio_regs_props u_props (.clk, .rst, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .response, .cpu_instr_prio, .display_ctl_prio, .pin_select_0,
  .rtc_alarm_out, .gpio_bank0_bit8_out, .gpio_bank0_bit8_oe_n, .pin_in, .deep_sleep_input,
  .serial2_clear_to_send, .gpio_bank0_bit8_in, .pin_out, .pin_oe_n);

// ===== test/tb.sv
// testbench: register map, fault capture and pin steering scenarios
`timescale 1ns/1ns
module tb;
  logic clk, rst, read, write, fault_valid, fault_user, fault_exec, fault_write, fault_clear;
  logic rtc_alarm_out, gpio_bank0_bit8_out, gpio_bank0_bit8_oe_n, ext_drive, ext_level;
  logic [5:0]  address;
  logic [31:0] writedata, rdata;
  logic [3:0]  byteenable;
  logic [1:0]  rresp;
  wire  [31:0] readdata, pin_select_0;
  wire  [1:0]  response;
  wire  waitrequest, pin_in, pin_out, pin_oe_n, deep_sleep_input, serial2_clear_to_send, gpio_bank0_bit8_in;
  wire  [2:0]  cpu_instr_prio, cpu_data_prio, parallel_stream_port_prio, video_dma_b_prio, video_dma_a_prio;
  wire  [2:0]  dma_ctl1_tc_a_prio, dma_ctl0_tc_b_prio, dma_ctl0_tc_a_prio, rt_unit_b_prio, rt_unit_a_prio;
  wire  [2:0]  display_ctl_prio, host_port_prio, usb_dma_port_prio, usb_cfg_port_prio;
  wire  [20:0] prio_a = {cpu_instr_prio, cpu_data_prio, parallel_stream_port_prio, video_dma_b_prio,
                         video_dma_a_prio, dma_ctl1_tc_a_prio, dma_ctl0_tc_b_prio};
  wire  [20:0] prio_b = {dma_ctl0_tc_a_prio, rt_unit_b_prio, rt_unit_a_prio, display_ctl_prio,
                         host_port_prio, usb_dma_port_prio, usb_cfg_port_prio};
  int n_errors = 0, samples_checked = 0;

  sysconfig_priority_pinmux_regs u_dut (.clk, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .response, .fault_valid, .fault_user, .fault_exec, .fault_write, .fault_clear,
    .cpu_instr_prio, .cpu_data_prio, .parallel_stream_port_prio, .video_dma_b_prio, .video_dma_a_prio,
    .dma_ctl1_tc_a_prio, .dma_ctl0_tc_b_prio, .dma_ctl0_tc_a_prio, .rt_unit_b_prio, .rt_unit_a_prio,
    .display_ctl_prio, .host_port_prio, .usb_dma_port_prio, .usb_cfg_port_prio, .pin_select_0,
    .rtc_alarm_out, .gpio_bank0_bit8_out, .gpio_bank0_bit8_oe_n, .deep_sleep_input,
    .serial2_clear_to_send, .gpio_bank0_bit8_in, .pin_in, .pin_out, .pin_oe_n);
  pin_buffer_model u_pin (.pin_out, .pin_oe_n, .ext_drive, .ext_level, .pin_in);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one transfer; an idle cycle follows so back-to-back calls never double-drive
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    int n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        n_errors++;
        $display("[FAIL] %0t bus timeout", $time);
        end_of_test();
      end
      @(posedge clk);
    end
    rdata = readdata;
    rresp = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    bus(1'b0, a, 32'h0, 4'hf);
    check({rresp, rdata}, {er, exp});
  endtask

  task automatic t_reset();
    rd(6'h00, 32'h0, 2'b00);
    rd(6'h04, 32'h4444_2222, 2'b00);
    rd(6'h08, 32'h4444_0000, 2'b00);
    rd(6'h0c, 32'h5460_4404, 2'b00);
    rd(6'h10, 32'h0, 2'b00);
    check({prio_a, prio_b}, {21'o2244440, 21'o0005644});
  endtask

  task automatic t_prio();
    bus(1'b1, 6'h04, 32'h4447_2aff, 4'hf);
    bus(1'b1, 6'h08, 32'h3541_7edb, 4'hf);
    bus(1'b1, 6'h0c, 32'h1400_3104, 4'hf);
    bus(1'b1, 6'h0c, 32'h7400_0000, 4'h8);
    rd(6'h04, 32'h4447_2277, 2'b00);
    rd(6'h08, 32'h3541_7653, 2'b00);
    rd(6'h0c, 32'h7400_3104, 2'b00);
    check({prio_a, prio_b}, {21'o7773517, 21'o6537031});
  endtask

  task automatic t_unmapped();
    bus(1'b1, 6'h14, 32'hffff_ffff, 4'hf);
    check(rresp, 2'b11);
    rd(6'h14, 32'h0, 2'b11);
    rd(6'h10, 32'h0, 2'b00);
  endtask

  // a second fault in the next cycle must not overwrite the first
  task automatic t_fault();
    for (int i = 0; i < 6; i++)
    begin
      fault_user <= (i < 3);
      fault_exec <= (i % 3 == 0);
      fault_write <= (i % 3 == 1);
      fault_valid <= 1'b1;
      fault_clear <= 1'b1;
      @(posedge clk);
      fault_clear <= 1'b0;
      fault_user <= (i >= 3);
      @(posedge clk);
      fault_valid <= 1'b0;
      @(posedge clk);
      rd(6'h00, {26'h0, 6'h01 << (i % 3 + (i < 3 ? 0 : 3))}, 2'b00);
    end
    fault_clear <= 1'b1;
    @(posedge clk);
    fault_clear <= 1'b0;
    @(posedge clk);
    rd(6'h00, 32'h0, 2'b00);
  endtask

  task automatic t_pin();
    logic [3:0] sels [5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h5};
    logic       drv;
    logic       exp;
    for (int s = 0; s < 5; s++)
      for (int lv = 0; lv < 2; lv++)
      begin
        bus(1'b1, 6'h10, {sels[s], 28'h0}, 4'hf);
        rd(6'h10, {sels[s], 28'h0}, 2'b00);
        rtc_alarm_out <= lv[0];
        gpio_bank0_bit8_out <= !lv[0];
        gpio_bank0_bit8_oe_n <= 1'b0;
        ext_level <= lv[0];
        ext_drive <= 1'b1;
        drv = (sels[s] == 4'h2 || sels[s] == 4'h8);
        exp = lv[0] ^ (sels[s] == 4'h8);
        repeat (6) @(posedge clk);
        check({pin_oe_n, pin_out & drv, deep_sleep_input, serial2_clear_to_send, gpio_bank0_bit8_in},
              {!drv, exp & drv, {3{exp}}});
      end
  endtask

  initial
  begin
    rst = 1'b1;
    {read, write, fault_valid, fault_user, fault_exec, fault_write, fault_clear} = '0;
    {rtc_alarm_out, gpio_bank0_bit8_out, gpio_bank0_bit8_oe_n, ext_drive, ext_level} = 5'h04;
    {address, writedata, byteenable} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_prio();
    t_unmapped();
    t_fault();
    t_pin();
    end_of_test();
  end
endmodule
